// ===== bench/remote_uart_model.sv
// Remote UART on the serial line: sends frames and catches frames
`timescale 1ns/1ns
`default_nettype none
module remote_uart_model (
  // Clock
  input wire logic mclk,
  // Serial line
  input wire logic txd,
  output logic rxd
);
  int bit_cycles = 32;
  int data_bits = 9;
  int frames = 0;
  logic listen = 1'b0;
  logic caught_stop = 1'b0;
  logic [8:0] caught = 9'h000;
  // Idle line is pulled high
  initial rxd = 1'b1;
  // One frame: start, data low bit first, ninth bit if any, stop
  task automatic send(input logic [8:0] data, input logic stop);
    rxd <= 1'b0;
    repeat (bit_cycles) @(posedge mclk);
    for (int i = 0; i < data_bits; i++) begin
      rxd <= data[i];
      repeat (bit_cycles) @(posedge mclk);
    end
    rxd <= stop;
    repeat (bit_cycles) @(posedge mclk);
    rxd <= 1'b1;
  endtask
  // Catch frames on txd at mid bit
  initial begin
    forever begin
      @(negedge txd);
      if (listen) begin
        repeat (bit_cycles / 2) @(posedge mclk);
        for (int i = 0; i < data_bits; i++) begin
          repeat (bit_cycles) @(posedge mclk);
          caught[i] = txd;
        end
        repeat (bit_cycles) @(posedge mclk);
        caught_stop = txd;
        frames++;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/uart_multiproc_baud_control_bench.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ns
`default_nettype none
module uart_multiproc_baud_control_bench;
  import uart_ctl_pkg::*;
  logic mclk, srst, reg_write, reg_read, rxd_out, rxd_oe, txd, serial_irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic line_rx;
  wire rxd_in;
  int mismatches, comparisons;
  // Shared data line in the shift mode
  assign rxd_in = rxd_oe ? rxd_out : line_rx;
  uart_multiproc_baud_control uart_multiproc_baud_control_i (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
    .serial_irq(serial_irq)
  );
  remote_uart_model remote_uart_model_i (
    .mclk(mclk), .txd(txd), .rxd(line_rx)
  );
  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_frame(input int limit);
    int base, k;
    base = remote_uart_model_i.frames;
    k = 0;
    while (remote_uart_model_i.frames == base && k < limit) begin
      @(posedge mclk);
      k++;
    end
    check({7'h00, k < limit}, 8'h01);
  endtask
  task automatic tx_frame(input logic [7:0] ctl, sel, input int cyc, nb,
                          input logic [7:0] data);
    logic [7:0] d;
    remote_uart_model_i.bit_cycles = cyc;
    remote_uart_model_i.data_bits = nb;
    remote_uart_model_i.listen = 1'b1;
    wr(ADDR_CLOCKS, sel);
    wr(ADDR_CONTROL, ctl);
    wr(ADDR_BUFFER, data);
    wait_frame(20 * cyc);
    check(remote_uart_model_i.caught[7:0], data);
    check({7'h00, remote_uart_model_i.caught_stop}, 8'h01);
    if (nb == 9) begin
      check({7'h00, remote_uart_model_i.caught[8]}, {7'h00, ctl[3]});
    end
    rd(ADDR_CONTROL, d);
    check({6'h00, d[1:0]}, 8'h02);
    check({7'h00, serial_irq}, 8'h01);
    wr(ADDR_CONTROL, ctl);
    repeat (2) @(posedge mclk);
    check({7'h00, serial_irq}, 8'h00);
    remote_uart_model_i.listen = 1'b0;
    repeat (cyc) @(posedge mclk);
  endtask
  task automatic rx_frame(input logic [7:0] ctl, input int cyc, nb,
                          input logic [8:0] data, input logic stop, hit);
    logic [7:0] d;
    remote_uart_model_i.bit_cycles = cyc;
    remote_uart_model_i.data_bits = nb;
    wr(ADDR_CONTROL, ctl);
    remote_uart_model_i.send(data, stop);
    repeat (2) @(posedge mclk);
    rd(ADDR_CONTROL, d);
    check({7'h00, d[0]}, {7'h00, hit});
    if (hit) begin
      check({7'h00, d[2]}, {7'h00, (nb == 9 ? data[8] : stop)});
      rd(ADDR_BUFFER, d);
      check(d, data[7:0]);
    end
    wr(ADDR_CONTROL, ctl);
  endtask
  task automatic s_registers;
    logic [7:0] d;
    rd(ADDR_CONTROL, d);
    check(d, CONTROL_RESET);
    wr(4'hf, 8'h5a);
    rd(4'hf, d);
    check(d, 8'h00);
    wr(ADDR_CONTROL, 8'he8);
    rd(ADDR_CONTROL, d);
    check(d, 8'he8);
    wr(ADDR_RELOAD_HIGH, 8'hc3);
    rd(ADDR_RELOAD_HIGH, d);
    check(d, 8'hc3);
    wr(ADDR_T1_RELOAD, 8'hff);
    rd(ADDR_T1_RELOAD, d);
    check(d, 8'hff);
  endtask
  task automatic s_transmit;
    tx_frame(8'h88, 8'h01, 32, 9, 8'ha5);
    tx_frame(8'h80, 8'h01, 32, 9, 8'h3c);
    tx_frame(8'h88, 8'h00, 64, 9, 8'h81);
    tx_frame(8'h40, 8'h01, 192, 8, 8'h96);
    tx_frame(8'hc0, 8'h00, 384, 9, 8'h5e);
  endtask
  task automatic s_receive;
    wr(ADDR_CLOCKS, 8'h01);
    rx_frame(8'hb0, 32, 9, 9'h055, 1'b1, 1'b0);
    rx_frame(8'hb0, 32, 9, 9'h1a7, 1'b1, 1'b1);
    rx_frame(8'h90, 32, 9, 9'h033, 1'b1, 1'b1);
    rx_frame(8'h80, 32, 9, 9'h1ff, 1'b1, 1'b0);
    rx_frame(8'hf0, 192, 9, 9'h011, 1'b1, 1'b0);
    rx_frame(8'h70, 192, 8, 9'h0c3, 1'b0, 1'b0);
    rx_frame(8'h50, 192, 8, 9'h0c3, 1'b1, 1'b1);
  endtask
  task automatic s_shift;
    logic [7:0] d;
    int k;
    wr(ADDR_CONTROL, 8'h20);
    wr(ADDR_BUFFER, 8'h69);
    k = 0;
    while (rxd_oe !== 1'b1 && k < 40) begin
      @(posedge mclk);
      k++;
    end
    check({7'h00, rxd_oe}, 8'h01);
    // Mid-bit samples of the data line, one bit per twelve cycles
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      d[i] = rxd_out;
      if (i < 7) begin
        repeat (12) @(posedge mclk);
      end
    end
    check(d, 8'h69);
    check({7'h00, serial_irq}, 8'h00);
    k = 0;
    while (serial_irq !== 1'b1 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    rd(ADDR_CONTROL, d);
    check({6'h00, d[1:0]}, 8'h02);
    wr(ADDR_CONTROL, 8'h00);
  endtask
  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    complete_run;
  end
  // Main sequence
  initial begin
    mismatches = 0;
    comparisons = 0;
    srst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    s_registers;
    s_transmit;
    s_receive;
    s_shift;
    complete_run;
  end
endmodule
`default_nettype wire

// ===== bench/uart_multiproc_baud_control_properties.sv
// Port-level assertions for the serial port control block
`timescale 1ns/1ns
`default_nettype none
module uart_ctl_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Serial line and request
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd,
  input wire logic serial_irq
);
  import uart_ctl_pkg::*;
  logic [1:0] mode_q;
  logic [4:0] ctl_top;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // Software-owned control bits of the write data
  assign ctl_top = reg_wdata[7:3];
  // Mode last written by software
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q <= 2'h0;
    end else if (reg_write && reg_addr == ADDR_CONTROL) begin
      mode_q <= reg_wdata[7:6];
    end
  end
  property p_reset_state;
    $fell(srst) |-> txd && !rxd_oe && !serial_irq && reg_rdata == 8'h00;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not idle after reset");
  property p_rdata_idle;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read answer");
  property p_unmapped;
    reg_read && reg_addr > ADDR_RELOAD_HIGH |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_ctrl_readback;
    reg_write && reg_addr == ADDR_CONTROL ##1
      reg_read && reg_addr == ADDR_CONTROL
      |=> reg_rdata[7:3] == $past(ctl_top, 2);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control bits not kept");
  property p_byte_readback;
    reg_write && reg_addr >= ADDR_T1_RELOAD && reg_addr <= ADDR_RELOAD_HIGH
      ##1 reg_read && reg_addr == $past(reg_addr)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_byte_readback: assert property (p_byte_readback)
    else $error("reload byte not kept");
  property p_irq_read;
    reg_read && reg_addr == ADDR_CONTROL && serial_irq |=> reg_rdata[1:0] != 2'h0;
  endproperty
  a_irq_read: assert property (p_irq_read)
    else $error("request without flag");
  property p_irq_fall;
    $fell(serial_irq) |-> ($past(reg_write) && $past(reg_addr) == ADDR_CONTROL)
      || ($past(reg_write, 2) && $past(reg_addr, 2) == ADDR_CONTROL);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("flag cleared without write");
  property p_oe_mode;
    (mode_q != 2'h0) [*4] |-> !rxd_oe;
  endproperty
  a_oe_mode: assert property (p_oe_mode)
    else $error("data line driven outside shift mode");
endmodule
bind uart_multiproc_baud_control uart_ctl_checker uart_ctl_checker_i (
  .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
  .serial_irq(serial_irq)
);
`default_nettype wire

// ===== rtl/uart_ctl_pkg.sv
// Constants and types shared by the serial port control block
package uart_ctl_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_BUFFER = 4'h1;
  localparam logic [3:0] ADDR_CLOCKS = 4'h2;
  localparam logic [3:0] ADDR_T1_RELOAD = 4'h3;
  localparam logic [3:0] ADDR_RELOAD_LOW = 4'h4;
  localparam logic [3:0] ADDR_RELOAD_HIGH = 4'h5;
  // Control register bit positions
  localparam int BIT_MODE_LOW = 7;
  localparam int BIT_MODE_HIGH = 6;
  localparam int BIT_FILTER = 5;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;
  // Clock select register bit positions
  localparam int BIT_DOUBLER = 0;
  localparam int BIT_TX_T2 = 1;
  localparam int BIT_RX_T2 = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Dividers in oscillator cycles
  localparam logic [7:0] DIV_MODE0 = 8'h0c;
  localparam logic [7:0] DIV_MODE2_SLOW = 8'h40;
  localparam logic [7:0] DIV_MODE2_FAST = 8'h20;
  localparam logic [7:0] DIV_MACHINE = 8'h0c;
  localparam logic [4:0] T1_TICKS_SLOW = 5'h1f;
  localparam logic [4:0] T2_TICKS = 5'h0f;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_S1 = 4'h7;
  localparam logic [3:0] OVS_S3 = 4'h9;
  localparam logic [3:0] OVS_HALF = 4'h8;
  localparam logic [3:0] BITS_MODE0 = 4'h8;
  localparam logic [3:0] BITS_MODE1 = 4'h9;
  localparam logic [3:0] BITS_MODE23 = 4'ha;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  // Mode selection by (mode_bit_low, mode_bit_high)
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_UART8 = 2'h1,
    MODE_FIXED9 = 2'h2,
    MODE_VAR9 = 2'h3
  } mode_type;
endpackage

// ===== rtl/uart_frame_rx.sv
// Receive bit detector: three-sample majority vote at mid bit
`timescale 1ns/1ns
`default_nettype none
module uart_frame_rx (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Sixteenth-bit tick and line
  input wire logic tick,
  input wire logic rxd,
  input wire logic restart,
  // Voted bit
  output logic bit_valid,
  output logic bit_value
);
  import uart_ctl_pkg::*;
  typedef struct packed {
    logic [3:0] phase;
    logic [2:0] votes;
    logic valid;
    logic value;
  } det_type;
  det_type q, next_q;

  // Sample at phases 7, 8, 9 and take the majority
  always_comb begin
    next_q = q;
    next_q.valid = 1'b0;
    if (restart) begin
      next_q.phase = 4'h0;
    end else if (tick) begin
      next_q.phase = q.phase + 4'h1;
      if (q.phase >= OVS_S1 && q.phase <= OVS_S3) begin
        next_q.votes = {q.votes[1:0], rxd};
      end
      if (q.phase == OVS_S3) begin
        next_q.valid = 1'b1;
        next_q.value = (q.votes[1] & q.votes[0]) |
          (q.votes[1] & rxd) | (q.votes[0] & rxd); // R24
      end
    end
    if (srst) begin
      next_q = '0;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    q <= next_q;
  end

  assign bit_valid = q.valid;
  assign bit_value = q.value;
endmodule
`default_nettype wire

// ===== rtl/uart_multiproc_baud_control.sv
// Serial port: control register, transmit and receive engines, rates
// How it works
// R1: Modes 2/3 with filter: receive flag only when ninth bit is one.
// R2: Master sends addresses with ninth bit one, data with zero.
// R3: Filter ignored in mode 0; mode 1 filter needs valid stop bit.
// R4: Control bits 7..0: modes, filter, rx enable, ninth bits, flags.
// R5: Mode pair selects shift register, 8-bit or 9-bit UART.
// R6: Reception only while receive enable is set.
// R7: Modes 2/3 send the written transmit ninth bit.
// R8: Receive ninth bit holds ninth bit, or mode 1 stop bit.
// R9: Transmit flag set at end of data or stop start; software clears.
// R10: Receive flag set at end of data or mid stop; software clears.
// R11: Mode 0 rate is oscillator over twelve.
// R12: Mode 2 rate is oscillator over 64, or 32 when doubled.
// R13: Timer 1 rate: overflow times doubler factor over 32.
// R14: Timer 1 auto-reload byte sets the overflow period.
// R15: Software may reload timer 1 itself for very low rates; here software writes only the reload byte, not the timer.
// R16: Timer 2 clock selects pick sources per direction.
// R17: Clock selects live in their own register for this port.
// R18: Timer 2 reloads from the sixteen-bit reload pair on rollover.
// R19: Timer 2 rate is overflow rate over sixteen.
// R20: Addressed slave clears its filter bit to take data.
// R21: Buffer write starts transmit; read returns separate receive byte.
// R22: Mode 1 frame: start zero, eight data LSB first, stop one.
// R23: Outside mode 0, start bit begins reception only when enabled.
// R24: Bit value is majority of three samples.
// R25: One interrupt request while either flag is set.
`timescale 1ns/1ns
`default_nettype none
module uart_multiproc_baud_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Serial line
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  // Interrupt request
  output logic serial_irq
);
  import uart_ctl_pkg::*;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_SEND = 3'b100
  } tx_state_type;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_FRAME = 3'b010,
    RX_SHIFT = 3'b100
  } rx_state_type;

  typedef struct packed {
    logic [7:0] control;
    logic [2:0] clocks;
    logic [7:0] t1_reload;
    logic [15:0] reload_pair;
    logic [7:0] rx_buffer;
    tx_state_type tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_count;
    logic [3:0] tx_sub;
    rx_state_type rx_state;
    logic [9:0] rx_shift;
    logic [3:0] rx_count;
    logic rx_prev;
    logic [7:0] rdata;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
  } port_type;
  port_type q, next_q;

  uart_tick_if ticks ();
  mode_type mode;
  logic bit_valid, bit_value, rx_restart, start_edge;
  logic tx_load, ninth_mode;
  logic [3:0] tx_bits;

  // Address match used by the register write path and the buffer load
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  // Enum code is {mode_bit_low, mode_bit_high}: (1,0) fixed 9-bit, (0,1) 8-bit UART, (1,1) variable 9-bit
  assign mode = mode_type'({q.control[BIT_MODE_LOW],
    q.control[BIT_MODE_HIGH]}); // R5
  assign ninth_mode = (mode == MODE_FIXED9) || (mode == MODE_VAR9);
  assign tx_load = reg_write && hit(reg_addr, ADDR_BUFFER);
  assign start_edge = q.rx_prev && !rxd_in;
  assign rx_restart = (q.rx_state == RX_IDLE);

  // Bit counts per frame: data, optional ninth, stop (mode 0: eight data bits only)
  always_comb begin
    case (mode)
      MODE_SHIFT: tx_bits = BITS_MODE0;
      MODE_UART8: tx_bits = BITS_MODE1;
      default: tx_bits = BITS_MODE23;
    endcase
  end

  uart_rate_gen rate_gen (
    .mclk(mclk),
    .srst(srst),
    .mode(mode),
    .baud_doubler(q.clocks[BIT_DOUBLER]),
    .tx_clock_select(q.clocks[BIT_TX_T2]),
    .rx_clock_select(q.clocks[BIT_RX_T2]),
    .timer1_reload_byte(q.t1_reload),
    .reload_pair(q.reload_pair),
    .ticks(ticks.source)
  );

  uart_frame_rx frame_rx (
    .mclk(mclk),
    .srst(srst),
    .tick(ticks.rx_tick),
    .rxd(rxd_in),
    .restart(rx_restart),
    .bit_valid(bit_valid),
    .bit_value(bit_value)
  );

  // Register writes, transmit and receive engines
  always_comb begin
    next_q = q;
    next_q.rx_prev = rxd_in;
    next_q.rdata = 8'h00;
    // Register writes
    if (reg_write) begin
      if (hit(reg_addr, ADDR_CONTROL)) begin
        next_q.control = reg_wdata; // R4 R6 R7 R20
      end
      if (hit(reg_addr, ADDR_CLOCKS)) begin
        next_q.clocks = reg_wdata[2:0]; // R17
      end
      if (hit(reg_addr, ADDR_T1_RELOAD)) begin
        next_q.t1_reload = reg_wdata; // R15
      end
      if (hit(reg_addr, ADDR_RELOAD_LOW)) begin
        next_q.reload_pair[7:0] = reg_wdata; // R18
      end
      if (hit(reg_addr, ADDR_RELOAD_HIGH)) begin
        next_q.reload_pair[15:8] = reg_wdata; // R18
      end
    end
    // Transmit engine
    case (q.tx_state)
      TX_IDLE: begin
        next_q.txd = 1'b1;
        next_q.rxd_oe = 1'b0;
      end
      TX_WAIT: begin
        if (ticks.tx_tick) begin
          next_q.tx_state = TX_SEND;
          next_q.tx_sub = 4'h0;
          next_q.tx_count = 4'h0;
          if (mode == MODE_SHIFT) begin
            next_q.rxd_oe = 1'b1;
            next_q.rxd_out = q.tx_shift[0];
          end else begin
            next_q.txd = 1'b0; // R22
          end
        end
      end
      TX_SEND: begin
        if (mode == MODE_SHIFT) begin
          if (ticks.tx_tick) begin
            next_q.tx_shift = {1'b0, q.tx_shift[10:1]};
            next_q.rxd_out = q.tx_shift[1];
            next_q.tx_count = q.tx_count + 4'h1;
            if (q.tx_count == BITS_MODE0 - 4'h1) begin
              next_q.control[BIT_TX_DONE] = 1'b1; // R9
              next_q.tx_state = TX_IDLE;
            end
          end
        end else if (ticks.tx_tick) begin
          next_q.tx_sub = q.tx_sub + 4'h1;
          if (q.tx_sub == OVS_LAST) begin
            next_q.tx_count = q.tx_count + 4'h1;
            next_q.txd = q.tx_shift[0];
            next_q.tx_shift = {1'b1, q.tx_shift[10:1]};
            if (q.tx_count == tx_bits - 4'h1) begin
              next_q.control[BIT_TX_DONE] = 1'b1; // R9
            end
            if (q.tx_count == tx_bits) begin
              next_q.tx_state = TX_IDLE;
            end
          end
        end
      end
      default: next_q.tx_state = TX_IDLE;
    endcase
    if (tx_load) begin
      // Data LSB first, then ninth bit in 9-bit modes, then stop
      next_q.tx_shift = ninth_mode ?
        {1'b1, q.control[BIT_TX_NINTH], reg_wdata, 1'b1} :
        {2'b11, reg_wdata, 1'b1}; // R7 R21 R22
      next_q.tx_shift = {next_q.tx_shift[10:1], 1'b1};
      next_q.tx_shift = {1'b1, next_q.tx_shift[10:1]};
      next_q.tx_state = TX_WAIT; // R21
    end
    // Receive engine
    case (q.rx_state)
      RX_IDLE: begin
        if (mode == MODE_SHIFT) begin
          if (q.control[BIT_RX_ENABLE] && !q.control[BIT_RX_DONE]) begin
            next_q.rx_state = RX_SHIFT; // R6
            next_q.rx_count = 4'h0;
          end
        end else if (q.control[BIT_RX_ENABLE] && start_edge) begin
          next_q.rx_state = RX_FRAME; // R6 R23
          next_q.rx_count = 4'h0;
        end
      end
      RX_SHIFT: begin
        if (ticks.rx_tick) begin
          next_q.rx_shift = {rxd_in, q.rx_shift[9:1]};
          next_q.rx_count = q.rx_count + 4'h1;
          if (q.rx_count == BITS_MODE0 - 4'h1) begin
            next_q.rx_buffer = {rxd_in, q.rx_shift[9:3]};
            next_q.control[BIT_RX_DONE] = 1'b1; // R10 R3
            next_q.rx_state = RX_IDLE;
          end
        end
      end
      RX_FRAME: begin
        if (bit_valid) begin
          next_q.rx_count = q.rx_count + 4'h1;
          next_q.rx_shift = {bit_value, q.rx_shift[9:1]};
          if (q.rx_count == 4'h0 && bit_value) begin
            next_q.rx_state = RX_IDLE; // false start
          end else if (q.rx_count == tx_bits) begin
            next_q.rx_state = RX_IDLE;
            // Stop at mid bit; filter checks the ninth bit before it, or in mode 1 the stop bit itself
            if (!q.control[BIT_RX_DONE] &&
                (!q.control[BIT_FILTER] ||
                 (ninth_mode ? q.rx_shift[9] : bit_value))) begin
              next_q.control[BIT_RX_DONE] = 1'b1; // R1 R3 R10
              if (ninth_mode) begin
                next_q.rx_buffer = q.rx_shift[8:1];
                next_q.control[BIT_RX_NINTH] = q.rx_shift[9]; // R8
              end else begin
                next_q.rx_buffer = q.rx_shift[9:2];
                next_q.control[BIT_RX_NINTH] = bit_value; // R8
              end
            end
          end
        end
      end
      default: next_q.rx_state = RX_IDLE;
    endcase
    // Register reads, data one cycle later
    if (reg_read) begin
      case (reg_addr)
        ADDR_CONTROL: next_q.rdata = q.control;
        ADDR_BUFFER: next_q.rdata = q.rx_buffer; // R21
        ADDR_CLOCKS: next_q.rdata = {5'h00, q.clocks};
        ADDR_T1_RELOAD: next_q.rdata = q.t1_reload;
        ADDR_RELOAD_LOW: next_q.rdata = q.reload_pair[7:0];
        ADDR_RELOAD_HIGH: next_q.rdata = q.reload_pair[15:8];
        default: next_q.rdata = 8'h00;
      endcase
    end
    if (srst) begin
      next_q = '0;
      next_q.control = CONTROL_RESET;
      next_q.tx_state = TX_IDLE;
      next_q.rx_state = RX_IDLE;
      next_q.tx_shift = '1;
      next_q.txd = 1'b1;
      next_q.rxd_out = 1'b1;
      next_q.rx_prev = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    q <= next_q;
  end

  // Outputs
  assign reg_rdata = q.rdata;
  assign txd = (q.tx_state == TX_SEND && mode == MODE_SHIFT) ?
    ticks.tx_tick : q.txd;
  assign rxd_out = q.rxd_out;
  assign rxd_oe = q.rxd_oe;
  assign serial_irq = q.control[BIT_TX_DONE] | q.control[BIT_RX_DONE]; // R25
endmodule
`default_nettype wire

// ===== rtl/uart_rate_gen.sv
// Bit clock generator: timer 1 and timer 2 sources, fixed mode rates
`timescale 1ns/1ns
`default_nettype none
module uart_rate_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Configuration
  input wire uart_ctl_pkg::mode_type mode,
  input wire logic baud_doubler,
  input wire logic tx_clock_select,
  input wire logic rx_clock_select,
  input wire logic [7:0] timer1_reload_byte,
  input wire logic [15:0] reload_pair,
  // Ticks at sixteen times the bit rate, at the bit rate itself in mode 0
  uart_tick_if.source ticks
);
  import uart_ctl_pkg::*;
  typedef struct packed {
    logic [3:0] mach;
    logic [7:0] t1;
    logic [15:0] t2;
    logic [4:0] t1_pre;
    logic [4:0] t2_pre;
    logic [6:0] fix;
    logic tx_t;
    logic rx_t;
  } gen_type;
  gen_type q, next_q;
  logic mach_tick, t1_ovf, t2_ovf, t1_bit, t2_bit, fix_bit, fix_done;
  logic [7:0] fix_div;

  // Fixed divider for modes 0 and 2, per-bit granularity in mode 0, sixteenth-bit in mode 2
  always_comb begin
    if (mode == MODE_SHIFT) begin
      fix_div = DIV_MODE0; // R11 R5
    end else if (baud_doubler) begin
      fix_div = DIV_MODE2_FAST; // R12
    end else begin
      fix_div = DIV_MODE2_SLOW; // R12
    end
  end

  assign mach_tick = (q.mach == 4'(DIV_MACHINE - 8'h01));
  assign t1_ovf = mach_tick && (q.t1 == BYTE_MAX);
  assign t2_ovf = (q.t2 == 16'hffff);
  assign t1_bit = t1_ovf && (q.t1_pre == 5'h00);
  assign t2_bit = t2_ovf && (q.t2_pre == 5'h00);
  // Mode 0 ticks once per bit; mode 2 sixteen times per bit
  assign fix_done = (mode == MODE_SHIFT) ?
    (q.fix == 7'(fix_div - 8'h01)) :
    (q.fix == 7'((fix_div >> 4) - 8'h01));
  assign fix_bit = fix_done;

  // Timer 1 auto-reload, timer 2 baud generator, prescalers
  always_comb begin
    next_q = q;
    next_q.mach = mach_tick ? 4'h0 : q.mach + 4'h1;
    if (mach_tick) begin
      next_q.t1 = t1_ovf ? timer1_reload_byte : q.t1 + 8'h01; // R14
    end
    next_q.t2 = t2_ovf ? reload_pair : q.t2 + 16'h0001; // R18
    if (t1_ovf) begin
      // Overflows per sixteenth: 2 unless doubled, giving /32 per bit
      next_q.t1_pre = (q.t1_pre == 5'h00) ?
        (baud_doubler ? 5'h00 : 5'h01) : q.t1_pre - 5'h01; // R13
    end
    if (t2_ovf) begin
      next_q.t2_pre = 5'h00; // R19
    end
    next_q.fix = fix_done ? 7'h00 : q.fix + 7'h01;
    if (mode == MODE_SHIFT || mode == MODE_FIXED9) begin
      next_q.tx_t = fix_bit;
      next_q.rx_t = fix_bit;
    end else begin
      next_q.tx_t = tx_clock_select ? t2_bit : t1_bit; // R16 R17
      next_q.rx_t = rx_clock_select ? t2_bit : t1_bit; // R16 R17
    end
    if (srst) begin
      next_q = '0;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    q <= next_q;
  end

  assign ticks.tx_tick = q.tx_t;
  assign ticks.rx_tick = q.rx_t;
endmodule
`default_nettype wire

// ===== rtl/uart_tick_if.sv
// Bit clock ticks passed from the rate generator to the serial engine
`timescale 1ns/1ns
`default_nettype none
interface uart_tick_if;
  logic tx_tick;
  logic rx_tick;
  modport source (output tx_tick, output rx_tick);
  modport sink (input tx_tick, input rx_tick);
endinterface
`default_nettype wire
